// ### nfctw_pkg.sv
// shared constants and types for the nfc target wake-up and protocol detect block
package nfctw_pkg;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_WAKE_LEVEL = 5'h18;
  localparam logic [4:0] ADDR_PROTOCOL = 5'h19;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_WAKE_LEVEL = 8'h00;
  localparam logic [7:0] RST_PROTOCOL = 8'h00;
  // wake level fields
  localparam int WL_ID_SIZE_LO = 6;
  localparam int WL_SDD_EN = 5;
  localparam int WL_EXT_RANGE = 3;
  localparam int WL_THRESH_LO = 0;
  // protocol fields
  localparam int PR_WAKE_CMP = 7;
  localparam int PR_AVOID_CMP = 6;
  localparam int PR_POLL_CODING = 4;
  localparam int PR_PASSIVE_106_DETECTED = 3;
  localparam int PR_TYPE_B = 2;
  localparam int PR_RATE_LO = 0;
  localparam logic [7:0] PR_AUTOCLR_MASK = 8'h1f;
  // status fields
  localparam int IS_TX = 7;
  localparam int IS_RX_START = 6;
  localparam int IS_FIFO = 5;
  localparam int IS_CRC = 4;
  localparam int IS_PARITY = 3;
  localparam int IS_FIELD = 2;
  localparam int IS_COLL = 1;
  localparam int IS_NORESP = 0;
  // timing
  localparam int CLK_PERIOD_PS = 5_000;
  localparam int SLOT_FIRST_US_X1000 = 2_416_000;
  localparam int SLOT_NEXT_US_X1000 = 1_208_000;
  localparam int AVOID_WAIT_US = 75;
  // divide in nanoseconds so the 0.005 fraction of a microsecond survives
  localparam int SLOT_FIRST_CYC = SLOT_FIRST_US_X1000 / (CLK_PERIOD_PS / 1000);
  localparam int SLOT_NEXT_CYC = SLOT_NEXT_US_X1000 / (CLK_PERIOD_PS / 1000);
  localparam int AVOID_WAIT_CYC = AVOID_WAIT_US * 1_000_000 / CLK_PERIOD_PS;
  localparam int COLL_EDGES_LOW = 6;
  localparam int COLL_EDGES_HIGH = 7;
  typedef enum logic [1:0] {
    RATE_NONE = 2'b00, RATE_106 = 2'b01, RATE_212 = 2'b10, RATE_424 = 2'b11
  } nfctw_rate_t;
  typedef enum logic [1:0] {
    CMD_SENS_ALL = 2'b00, CMD_POLLING = 2'b01, CMD_ATR = 2'b10, CMD_TYPE_B = 2'b11
  } nfctw_cmd_t;
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000, MODE_PASSIVE_106_DETECTED = 3'b001, MODE_TAG_A = 3'b010,
    MODE_PAS_FAST = 3'b011, MODE_ACTIVE = 3'b100, MODE_TAG_B = 3'b101
  } nfctw_mode_t;
  typedef enum logic [1:0] {
    PU_IDLE = 2'b00, PU_WAIT_OSC = 2'b01, PU_WAIT_CMD = 2'b10, PU_DONE = 2'b11
  } nfctw_pu_t;
endpackage : nfctw_pkg

// ### nfctw_sync.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module nfctw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : nfctw_sync

// ### nfctw_timer.sv
// down-counting timer, one-shot or periodic after the first expiry
`timescale 1ns/10ps
module nfctw_timer #(
  parameter int WIDTH = 20
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_periodic,
  input wire logic [WIDTH-1:0] i_first,
  input wire logic [WIDTH-1:0] i_period,
  output logic o_tick
);
  logic [WIDTH-1:0] count;
  logic running;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
      running <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_stop) begin
        running <= 1'b0;
      end else if (i_start) begin
        count <= i_first - WIDTH'(1);
        running <= 1'b1;
      end else if (running) begin
        if (count == '0) begin
          o_tick <= 1'b1;
          running <= i_periodic;
          count <= i_period - WIDTH'(1);
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end
endmodule : nfctw_timer

// ### nfctw_core.sv
// nfc target wake-up, power-up handshake, first-command protocol detect and status
// Function
// - zero threshold switches rf detector off
// - extended-range bit selects higher threshold set
// - sdd enable runs internal 106k detection
// - two bits give identifier size
// - wake level cleared only by always-on reset
// - oscillator ok raises field-change interrupt
// - comparator outputs shown live in protocol
// - first command gives receive-start interrupt
// - coding bit reports polling or type-a style
// - flags for sens/all request and type b
// - two-bit code of first bit rate
// - protocol low bits clear after read
// - without sdd request goes to fifo
// - field loss in 106k mode interrupts
// - request selects passive 106 or tag a
// - polling gives fast passive, slot timing
// - atr gives active target, avoidance interrupt
// - type b with tag emulation enters b mode
// - status clears on reset, write, read end
// - tx/rx flags early, interrupt on completion
// - fifo, crc, parity, framing flags
// - collision edge count and no-response flag
// - wake level above threshold forces enable
`timescale 1ns/10ps
module nfctw_core #(
  parameter int SLOT_FIRST = nfctw_pkg::SLOT_FIRST_CYC,
  parameter int SLOT_NEXT = nfctw_pkg::SLOT_NEXT_CYC,
  parameter int AVOID_WAIT = nfctw_pkg::AVOID_WAIT_CYC,
  parameter int TW = 20
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_aon_rst_b,
  input wire logic i_en_pin,
  input wire logic i_wake_cmp_async,
  input wire logic i_avoid_cmp_async,
  input wire logic i_osc_ok_async,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_iso_ctrl_wr,
  input wire logic i_tag_emulation,
  input wire logic i_no_rx_crc,
  input wire logic i_iso15693,
  input wire logic i_coll_limit_high,
  input wire logic i_first_cmd,
  input wire nfctw_pkg::nfctw_cmd_t i_first_kind,
  input wire nfctw_pkg::nfctw_rate_t i_first_rate,
  input wire logic i_first_poll_coding,
  input wire logic i_tx_start,
  input wire logic i_tx_done,
  input wire logic i_rx_start,
  input wire logic i_rx_done,
  input wire logic i_fifo_level,
  input wire logic i_crc_err,
  input wire logic i_parity_err,
  input wire logic i_framing_err,
  input wire logic i_rx_edge,
  input wire logic i_bit_end,
  input wire logic i_noresp_timeout,
  input wire logic i_avoid_cmd,
  input wire logic i_own_field_on,
  output logic [7:0] o_reg_rdata,
  output logic o_irq,
  output logic o_detector_on,
  output logic [2:0] o_wake_threshold,
  output logic o_extended_range_select,
  output logic o_force_enable,
  output logic [1:0] o_id_size,
  output logic o_internal_sdd_run,
  output logic o_forward_to_fifo,
  output logic o_clock_extractor_en,
  output nfctw_pkg::nfctw_mode_t o_mode,
  output logic o_slot_tick
);
  import nfctw_pkg::*;

  if (TW < 17 || SLOT_FIRST < 1 || SLOT_NEXT < 1 || AVOID_WAIT < 1 ||
      SLOT_FIRST >= (1 << TW) || AVOID_WAIT >= (1 << TW)) begin : g_chk
    $error("timer width too small for the configured counts");
  end

  logic en_s;
  logic wake_s;
  logic avoid_s;
  logic osc_s;
  logic wake_d;
  logic osc_d;
  logic [7:0] wake_level;
  logic [7:0] proto_low;
  logic [7:0] irq_status;
  logic [7:0] next_irq_status;
  logic [7:0] set_vec;
  logic [3:0] edge_count;
  logic rd_status_d;
  logic rd_proto_d;
  logic enable_active;
  logic field_event;
  logic irq_req;
  logic status_clr;
  logic first_take;
  logic slot_tick_raw;
  logic avoid_tick;
  logic coll_hit;
  nfctw_pu_t pu_state;
  nfctw_mode_t next_mode;

  nfctw_sync #(.WIDTH(4)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_async({i_en_pin, i_wake_cmp_async, i_avoid_cmp_async, i_osc_ok_async}),
    .o_sync({en_s, wake_s, avoid_s, osc_s})
  );

  function automatic logic [7:0] nfctw_addr_hit(input logic [4:0] a, input logic [4:0] r);
    nfctw_addr_hit = (a == r) ? 8'hff : 8'h00;
  endfunction : nfctw_addr_hit

  always_ff @(posedge i_mclk or negedge i_aon_rst_b) begin
    if (!i_aon_rst_b) begin
      wake_level <= RST_WAKE_LEVEL;
    end else if (i_reg_wr && i_reg_addr == ADDR_WAKE_LEVEL) begin
      wake_level <= i_reg_wdata & 8'hef;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_detector_on <= 1'b0;
      o_wake_threshold <= 3'h0;
      o_extended_range_select <= 1'b0;
      o_id_size <= 2'h0;
    end else begin
      o_detector_on <= wake_level[WL_THRESH_LO +: 3] != 3'h0;
      o_wake_threshold <= wake_level[WL_THRESH_LO +: 3];
      o_extended_range_select <= wake_level[WL_EXT_RANGE];
      o_id_size <= wake_level[WL_ID_SIZE_LO +: 2];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_d <= 1'b0;
      osc_d <= 1'b0;
    end else begin
      wake_d <= wake_s;
      osc_d <= osc_s;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_force_enable <= 1'b0;
    end else if (pu_state == PU_IDLE) begin
      o_force_enable <= o_detector_on && wake_s;
    end else if (pu_state == PU_DONE || (pu_state == PU_WAIT_CMD && i_rx_done && !en_s)) begin
      o_force_enable <= 1'b0;
    end
  end

  assign enable_active = en_s || o_force_enable;

  // power-up handshake
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pu_state <= PU_IDLE;
    end else begin
      case (pu_state)
        PU_IDLE: begin
          if (o_force_enable) begin
            pu_state <= PU_WAIT_OSC;
          end
        end
        PU_WAIT_OSC: begin
          if (osc_s) begin
            pu_state <= PU_WAIT_CMD;
          end
        end
        PU_WAIT_CMD: begin
          if (i_rx_done) begin
            pu_state <= en_s ? PU_DONE : PU_IDLE;
          end else if (!enable_active) begin
            pu_state <= PU_IDLE;
          end
        end
        PU_DONE: begin
          if (!en_s) begin
            pu_state <= PU_IDLE;
          end
        end
        default: pu_state <= PU_IDLE;
      endcase
    end
  end

  assign first_take = i_first_cmd && o_mode == MODE_NONE && enable_active;

  always_comb begin
    next_mode = o_mode;
    if (!enable_active) begin
      next_mode = MODE_NONE;
    end else if (first_take) begin
      case (i_first_kind)
        CMD_SENS_ALL: next_mode = i_tag_emulation ? MODE_TAG_A : MODE_PASSIVE_106_DETECTED;
        CMD_POLLING: next_mode = MODE_PAS_FAST;
        CMD_ATR: next_mode = MODE_ACTIVE;
        // type b emulation only when selected
        CMD_TYPE_B: next_mode = i_tag_emulation ? MODE_TAG_B : MODE_NONE;
        default: next_mode = MODE_NONE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mode <= MODE_NONE;
      o_clock_extractor_en <= 1'b0;
      o_internal_sdd_run <= 1'b0;
      o_forward_to_fifo <= 1'b0;
    end else begin
      o_mode <= next_mode;
      // clock extractor in type a modes
      o_clock_extractor_en <= next_mode == MODE_PASSIVE_106_DETECTED || next_mode == MODE_TAG_A;
      o_internal_sdd_run <= wake_level[WL_SDD_EN] &&
                            (next_mode == MODE_PASSIVE_106_DETECTED || next_mode == MODE_TAG_A);
      o_forward_to_fifo <= first_take && i_first_kind == CMD_SENS_ALL && !wake_level[WL_SDD_EN];
    end
  end

  nfctw_timer #(.WIDTH(TW)) u_slot (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_start(first_take && i_first_kind == CMD_POLLING && i_rx_done),
    .i_stop(o_mode != MODE_PAS_FAST && !first_take),
    .i_periodic(1'b1),
    .i_first(TW'(SLOT_FIRST)),
    .i_period(TW'(SLOT_NEXT)),
    .o_tick(slot_tick_raw)
  );

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_slot_tick <= 1'b0;
    end else begin
      o_slot_tick <= slot_tick_raw;
    end
  end

  nfctw_timer #(.WIDTH(TW)) u_avoid (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_start(i_avoid_cmd),
    .i_stop(!enable_active),
    .i_periodic(1'b0),
    .i_first(TW'(AVOID_WAIT)),
    .i_period(TW'(AVOID_WAIT)),
    .o_tick(avoid_tick)
  );

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_count <= 4'h0;
    end else if (i_bit_end) begin
      edge_count <= 4'h0;
    end else if (i_rx_edge && edge_count != 4'hf) begin
      edge_count <= edge_count + 4'h1;
    end
  end

  // four bits so that more than seven edges can still be told apart
  assign coll_hit = i_bit_end && (edge_count > (i_coll_limit_high ?
                    4'(COLL_EDGES_HIGH) : 4'(COLL_EDGES_LOW)));

  assign field_event = (pu_state == PU_WAIT_OSC && osc_s && !osc_d) ||
                       ((o_mode == MODE_PASSIVE_106_DETECTED || o_mode == MODE_TAG_A) && wake_d && !wake_s);

  always_comb begin
    set_vec = 8'h00;
    set_vec[IS_TX] = i_tx_start;
    set_vec[IS_RX_START] = i_rx_start || (first_take && pu_state == PU_WAIT_CMD);
    set_vec[IS_FIFO] = i_fifo_level;
    set_vec[IS_CRC] = i_crc_err && !i_no_rx_crc;
    set_vec[IS_PARITY] = i_parity_err;
    set_vec[IS_FIELD] = i_framing_err || field_event;
    set_vec[IS_COLL] = coll_hit || (avoid_tick && i_own_field_on);
    set_vec[IS_NORESP] = i_noresp_timeout && i_iso15693;
  end

  assign irq_req = (i_tx_done && irq_status[IS_TX]) ||
                   (i_rx_done && irq_status[IS_RX_START]) || (set_vec[5:0] != 6'h00);

  assign status_clr = !enable_active || i_iso_ctrl_wr || rd_status_d;

  always_comb begin
    next_irq_status = status_clr ? set_vec : (irq_status | set_vec);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_status <= RST_IRQ_STATUS;
      o_irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      o_irq <= irq_req || (o_irq && !status_clr);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      proto_low <= RST_PROTOCOL;
    end else if (first_take) begin
      proto_low[PR_POLL_CODING] <= i_first_poll_coding;
      proto_low[PR_PASSIVE_106_DETECTED] <= i_first_kind == CMD_SENS_ALL;
      proto_low[PR_TYPE_B] <= i_first_kind == CMD_TYPE_B;
      proto_low[PR_RATE_LO +: 2] <= i_first_rate;
    end else if (!en_s && !o_force_enable) begin
      proto_low <= RST_PROTOCOL;
    end else if (rd_proto_d) begin
      proto_low <= proto_low & ~PR_AUTOCLR_MASK;
    end
  end

  // read data is registered, clears act one cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
      rd_status_d <= 1'b0;
      rd_proto_d <= 1'b0;
    end else begin
      rd_status_d <= i_reg_rd && i_reg_addr == ADDR_IRQ_STATUS;
      rd_proto_d <= i_reg_rd && i_reg_addr == ADDR_PROTOCOL;
      if (i_reg_rd) begin
        o_reg_rdata <= (nfctw_addr_hit(i_reg_addr, ADDR_IRQ_STATUS) & irq_status) |
                       (nfctw_addr_hit(i_reg_addr, ADDR_WAKE_LEVEL) & wake_level) |
                       (nfctw_addr_hit(i_reg_addr, ADDR_PROTOCOL) &
                        {wake_s, avoid_s, 1'b0, proto_low[4:0]});
      end
    end
  end

  sequence s_first_sens;
    first_take && i_first_kind == CMD_SENS_ALL;
  endsequence

  sequence s_read_proto;
    i_reg_rd && i_reg_addr == ADDR_PROTOCOL && !first_take;
  endsequence

  a_detector_zero_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wake_level[2:0] == 3'h0 |=> !o_detector_on)
    else $error("detector on with zero threshold");

  a_ext_range_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    1'b1 |=> o_extended_range_select == $past(wake_level[WL_EXT_RANGE]))
    else $error("extended range not following register");

  a_sens_mode_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_first_sens |=> (o_mode == MODE_PASSIVE_106_DETECTED || o_mode == MODE_TAG_A) && o_clock_extractor_en)
    else $error("request did not enter 106k mode");

  a_fifo_forward: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_first_sens ##0 !wake_level[WL_SDD_EN] |=> o_forward_to_fifo)
    else $error("request not forwarded to fifo");

  a_proto_autoclr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_read_proto ##1 !first_take |=> proto_low[4:0] == 5'h00)
    else $error("protocol bits not cleared after read");

  a_status_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_iso_ctrl_wr |=> irq_status == $past(set_vec))
    else $error("status not cleared on protocol select write");

  a_rx_irq_done: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_rx_start && !i_rx_done && !i_tx_done && set_vec[5:0] == 6'h00 && !status_clr && !o_irq
    |=> irq_status[IS_RX_START] && !o_irq)
    else $error("receive-start interrupt raised early");

  a_osc_field_irq: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pu_state == PU_WAIT_OSC && osc_s && !osc_d |=> o_irq && irq_status[IS_FIELD])
    else $error("no field-change interrupt on oscillator ok");

  a_crc_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_no_rx_crc && status_clr |=> !irq_status[IS_CRC])
    else $error("crc flag set while crc disabled");

  a_powerup_lapse: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pu_state == PU_WAIT_CMD && i_rx_done && !en_s |=> !o_force_enable ##1 pu_state == PU_IDLE)
    else $error("power-up did not lapse without enable");
endmodule : nfctw_core

// ### nfctw_remote.sv
// remote initiator model that sends first command frames to the target core
`timescale 1ns/10ps
module nfctw_remote (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [1:0] i_kind,
  input wire logic [1:0] i_rate,
  input wire logic i_coding,
  input wire logic [3:0] i_gap,
  output logic o_rx_start,
  output logic o_rx_done,
  output logic o_first_cmd,
  output nfctw_pkg::nfctw_cmd_t o_kind,
  output nfctw_pkg::nfctw_rate_t o_rate,
  output logic o_coding,
  output logic o_busy
);
  import nfctw_pkg::*;
  initial begin
    {o_rx_start, o_rx_done, o_first_cmd, o_coding, o_busy} = '0;
    o_kind = CMD_SENS_ALL;
    o_rate = RATE_NONE;
  end
  // start of frame, then decoded command at frame end
  always begin
    @(posedge i_mclk);
    if (i_go) begin
      o_busy = 1'b1;
      @(negedge i_mclk);
      o_rx_start = 1'b1;
      @(negedge i_mclk);
      o_rx_start = 1'b0;
      // gap sets a prompt or a slow frame
      repeat (i_gap) @(negedge i_mclk);
      o_kind = nfctw_cmd_t'(i_kind);
      o_rate = nfctw_rate_t'(i_rate);
      o_coding = i_coding;
      {o_first_cmd, o_rx_done} = 2'b11;
      @(negedge i_mclk);
      {o_first_cmd, o_rx_done} = 2'b00;
      // qualifiers turn stale once the frame is over
      o_kind = nfctw_cmd_t'(~i_kind);
      o_rate = nfctw_rate_t'(~i_rate);
      o_coding = ~i_coding;
      @(posedge i_mclk);
      o_busy = 1'b0;
    end
  end
endmodule : nfctw_remote

// ### testbench.sv
// self-checking bench for the target wake-up and protocol detect core
`timescale 1ns/10ps
module testbench;
  import nfctw_pkg::*;
  localparam int SF = 20;
  localparam int SN = 10;
  logic i_mclk = 1'b0;
  logic i_rst_b, i_aon_rst_b, i_en_pin, i_reg_wr, i_reg_rd, go, pc, fwd;
  logic i_wake_cmp_async, i_avoid_cmp_async, i_osc_ok_async, i_tag_emulation;
  logic i_no_rx_crc, i_iso15693, i_coll_limit_high, i_own_field_on;
  logic [4:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata;
  wire logic i_tx_start, i_tx_done, i_fifo_level, i_crc_err, i_parity_err, i_framing_err;
  wire logic i_rx_edge, i_bit_end, i_noresp_timeout, i_avoid_cmd, i_iso_ctrl_wr;
  wire logic i_rx_start, i_rx_done, i_first_cmd, i_first_poll_coding, busy;
  nfctw_cmd_t i_first_kind;
  nfctw_rate_t i_first_rate;
  nfctw_mode_t o_mode;
  logic o_irq, o_detector_on, o_extended_range_select, o_force_enable, o_internal_sdd_run;
  logic o_forward_to_fifo, o_clock_extractor_en, o_slot_tick;
  logic [2:0] o_wake_threshold;
  logic [1:0] o_id_size, pk, pr, rt;
  logic [3:0] gap;
  logic [10:0] ev;
  logic [31:0] seed, r;
  int checks, err_count, cycles, n;
  int eidx[5] = '{2, 3, 4, 5, 8};
  logic [7:0] ebit[5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
  assign {i_iso_ctrl_wr, i_avoid_cmd, i_noresp_timeout, i_bit_end, i_rx_edge, i_framing_err,
    i_parity_err, i_crc_err, i_fifo_level, i_tx_done, i_tx_start} = ev;

  nfctw_core #(.SLOT_FIRST(SF), .SLOT_NEXT(SN), .AVOID_WAIT(8)) nfctw_core_inst (.*);
  nfctw_remote nfctw_remote_inst (.i_mclk(i_mclk), .i_go(go), .i_kind(pk), .i_rate(pr),
    .i_coding(pc), .i_gap(gap), .o_rx_start(i_rx_start), .o_rx_done(i_rx_done),
    .o_first_cmd(i_first_cmd), .o_kind(i_first_kind), .o_rate(i_first_rate),
    .o_coding(i_first_poll_coding), .o_busy(busy));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // hang guard, and a sticky copy of the one-cycle forward pulse
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    fwd <= o_forward_to_fifo || (fwd && !go);
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] exp_mode(input logic [1:0] k, input logic t);
    case (k)
      2'b00: return t ? MODE_TAG_A : MODE_PASSIVE_106_DETECTED;
      2'b01: return MODE_PAS_FAST;
      2'b10: return MODE_ACTIVE;
      default: return t ? MODE_TAG_B : MODE_NONE;
    endcase
  endfunction : exp_mode

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(negedge i_mclk);
  endtask : cyc

  task automatic pulse(input int k);
    ev[k] = 1'b1;
    cyc(1);
    ev[k] = 1'b0;
    cyc(1);
  endtask : pulse

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cyc(1);
    i_reg_rd = 1'b0;
    chk(nm, e, o_reg_rdata);
    cyc(1);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rst_core();
    i_rst_b = 1'b0;
    cyc(2);
    i_rst_b = 1'b1;
    cyc(3);
  endtask : rst_core

  task automatic send(input logic [1:0] k, input logic [1:0] rate, input logic c);
    logic [31:0] g;
    g = rnd();
    {pk, pr, pc, gap} = {k, rate, c, g[11:8]};
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (n = 0; n < 40 && busy; n++) cyc(1);
  endtask : send

  task automatic wait_tick();
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!o_slot_tick && n < 60);
  endtask : wait_tick

  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    {i_rst_b, i_aon_rst_b, i_en_pin, i_reg_wr, i_reg_rd, go, pc} = '0;
    {i_wake_cmp_async, i_avoid_cmp_async, i_osc_ok_async, i_tag_emulation} = '0;
    {i_no_rx_crc, i_iso15693, i_coll_limit_high, i_own_field_on} = '0;
    {i_reg_addr, i_reg_wdata, pk, pr, rt, gap, ev} = '0;
    seed = 32'h0000_8ace;
    cyc(4);
    {i_aon_rst_b, i_rst_b, i_en_pin} = 3'b111;
    cyc(3);
    rd(ADDR_IRQ_STATUS, RST_IRQ_STATUS, "status");
    rd(ADDR_WAKE_LEVEL, RST_WAKE_LEVEL, "wake");
    rd(ADDR_PROTOCOL, RST_PROTOCOL, "proto");
    rd(5'h05, 8'h00, "unmapped");
    wr(ADDR_IRQ_STATUS, 8'hff);
    rd(ADDR_IRQ_STATUS, 8'h00, "status ro");
    repeat (4) begin
      r = rnd();
      wr(ADDR_WAKE_LEVEL, r[7:0]);
      rd(ADDR_WAKE_LEVEL, r[7:0] & 8'hef, "wake rw");
      chk("thresh", r[2:0], o_wake_threshold);
      chk("det on", |r[2:0], o_detector_on);
      chk("ext", r[3], o_extended_range_select);
      chk("id size", r[7:6], o_id_size);
    end
    rst_core();
    rd(ADDR_WAKE_LEVEL, r[7:0] & 8'hef, "wake kept");
    i_aon_rst_b = 1'b0;
    cyc(1);
    i_aon_rst_b = 1'b1;
    rd(ADDR_WAKE_LEVEL, 8'h00, "wake aon");
    chk("det off", 8'h00, o_detector_on);
    wr(ADDR_WAKE_LEVEL, 8'h03);
    {i_en_pin, i_wake_cmp_async, i_avoid_cmp_async} = 3'b011;
    cyc(5);
    chk("force en", 8'h01, o_force_enable);
    rd(ADDR_PROTOCOL, 8'hc0, "proto cmp");
    i_osc_ok_async = 1'b1;
    cyc(5);
    chk("irq osc", 8'h01, o_irq);
    rd(ADDR_IRQ_STATUS, 8'h04, "status osc");
    // host confirms power-up between the two interrupts
    i_en_pin = 1'b1;
    send(2'b00, 2'b01, 1'b0);
    chk("mode", MODE_PASSIVE_106_DETECTED, o_mode);
    chk("fifo fwd", 8'h01, fwd);
    rd(ADDR_PROTOCOL, 8'hc9, "proto first");
    rd(ADDR_IRQ_STATUS, 8'h40, "status rx");
    i_wake_cmp_async = 1'b0;
    cyc(5);
    rd(ADDR_IRQ_STATUS, 8'h04, "field loss");
    i_avoid_cmp_async = 1'b0;
    // host never confirms: power-up lapses at the first command
    rst_core();
    {i_en_pin, i_wake_cmp_async} = 2'b01;
    cyc(5);
    send(2'b10, 2'b11, 1'b1);
    chk("lapse mode", MODE_NONE, o_mode);
    rd(ADDR_PROTOCOL, 8'h80, "lapse proto");
    {i_en_pin, i_wake_cmp_async} = 2'b10;
    for (int i = 0; i < 8; i++) begin
      rst_core();
      i_tag_emulation = i[2];
      r = rnd();
      rt = (r[1:0] == 2'b00) ? 2'b01 : r[1:0];
      // internal detection enabled on the tag emulation passes only
      wr(ADDR_WAKE_LEVEL, {2'b00, i[2], 5'h03});
      send(i[1:0], rt, r[2]);
      if (i[1:0] == 2'b01) begin
        wait_tick();
        chk("slot first", SF, n);
        wait_tick();
        chk("slot next", SN, n);
      end
      chk("mode", exp_mode(i[1:0], i[2]), o_mode);
      chk("clk extr", i[1:0] == 2'b00, o_clock_extractor_en);
      chk("sdd run", i[2] && i[1:0] == 2'b00, o_internal_sdd_run);
      chk("fwd", !i[2] && i[1:0] == 2'b00, fwd);
      chk("irq done", 8'h01, o_irq);
      if (exp_mode(i[1:0], i[2]) != MODE_NONE) begin
        rd(ADDR_PROTOCOL, {3'h0, r[2], i[1:0] == 2'b00, i[1:0] == 2'b11, rt}, "p");
        rd(ADDR_PROTOCOL, 8'h00, "proto clr");
      end
      rd(ADDR_IRQ_STATUS, 8'h40, "status rx");
      chk("irq clr", 8'h00, o_irq);
    end
    i_iso15693 = 1'b1;
    for (int j = 0; j < 5; j++) begin
      pulse(eidx[j]);
      rd(ADDR_IRQ_STATUS, ebit[j], "flag");
    end
    i_no_rx_crc = 1'b1;
    pulse(3);
    rd(ADDR_IRQ_STATUS, 8'h00, "crc off");
    for (int lim = 0; lim < 2; lim++) begin
      i_coll_limit_high = lim[0];
      repeat (7) pulse(6);
      pulse(7);
      rd(ADDR_IRQ_STATUS, lim[0] ? 8'h00 : 8'h02, "coll");
    end
    pulse(0);
    chk("irq tx", 8'h00, o_irq);
    pulse(1);
    chk("irq tx done", 8'h01, o_irq);
    rd(ADDR_IRQ_STATUS, 8'h80, "tx");
    pulse(2);
    pulse(10);
    rd(ADDR_IRQ_STATUS, 8'h00, "ctrl wr");
    chk("irq ctrl", 8'h00, o_irq);
    i_own_field_on = 1'b1;
    pulse(9);
    for (n = 0; n < 30 && !o_irq; n++) cyc(1);
    rd(ADDR_IRQ_STATUS, 8'h02, "avoid");
    print_verdict();
  end
endmodule : testbench
